// File: rtl/pfv_map.svh
`ifndef PFV_MAP_SVH
`define PFV_MAP_SVH

// Command codes of the word registers
`define PFV_CMD_VOUT_MIN      8'h2b
`define PFV_CMD_FREQ_SWITCH   8'h33
`define PFV_CMD_VIN_ON        8'h35

// SLINEAR11 field layout
`define PFV_EXP_MSB           15
`define PFV_EXP_LSB           11
`define PFV_MAN_MSB           10
`define PFV_MAN_LSB           0

// Reset exponent of the turn-on threshold, two's complement -2
`define PFV_TURN_ON_EXPONENT_RST       5'h1e

// Frequency write range in kHz, upper bound exclusive
`define PFV_FREQ_MIN_KHZ      12'h001
`define PFV_FREQ_MAX_KHZ      12'h671

// Largest positive 11-bit mantissa, used when building the exponent
`define PFV_MAN_POS_MAX       11'h3ff

// Turn-on threshold range in 1/16 V units: 2.50 V to 18.25 V
`define PFV_VON_MIN_16TH      10'h028
`define PFV_VON_MAX_16TH      10'h124
// Lowest threshold in 0.25 V steps (2.50 V)
`define PFV_VON_BASE_QTR      8'h0a

// Decoder scaling: frequency in kHz, turn-on voltage in 1/16 V
`define PFV_FREQ_SHIFT        0
`define PFV_VON_SHIFT         4

`endif

// File: rtl/pfv_pkg.sv
package pfv_pkg;

    // One PMBus data word
    typedef logic [15:0] pfv_word_t;

    // Hardware frequency setting in kHz
    typedef logic [10:0] pfv_khz_t;

    // Turn-on threshold hardware code, 0.25 V per step above 2.50 V
    typedef logic [5:0] pfv_von_code_t;

endpackage

// File: rtl/pfv_slinear_dec.sv
`timescale 1ns/1ps
// SLINEAR11 decoder: value scaled by 2^SHIFT, floored, saturated
module pfv_slinear_dec #(
    parameter int SHIFT = 0,  // Extra left shift for fractional units
    parameter int OUT_W = 12  // Width of the decoded value
) (
    input  wire logic [15:0]      word_i,    // SLINEAR11 word
    output logic      [OUT_W-1:0] value_o,   // Decoded magnitude
    output logic                  negative_o, // Value below zero
    output logic                  overflow_o  // Value above OUT_W range
);

    // Elaboration check on the scaling range
    if (SHIFT < 0 || SHIFT > 8 || OUT_W < 2 || OUT_W > 32) begin : g_chk
        $error("pfv_slinear_dec: unsupported SHIFT or OUT_W");
    end

    logic signed [5:0]  sh;   // Net shift amount
    logic signed [47:0] wide; // Mantissa after shifting

    ////////////////////////////////////////////////////////////////////////////////
    // Right shifts are arithmetic so a fraction always rounds down
    always_comb begin
        sh   = $signed({word_i[15], word_i[15:11]}) + $signed(6'(SHIFT));
        wide = 48'($signed(word_i[10:0]));
        if (sh >= 0) begin
            wide = wide <<< sh[4:0];
        end else begin
            wide = wide >>> 6'(-sh);
        end
        negative_o = wide[47];
        overflow_o = !wide[47] && (wide[46:OUT_W] != '0);
        if (negative_o) begin
            value_o = '0;
        end else if (overflow_o) begin
            value_o = '1;
        end else begin
            value_o = wide[OUT_W-1:0];
        end
    end

endmodule // pfv_slinear_dec

// File: rtl/pfv_freq_bin.sv
`timescale 1ns/1ps
// Maps a requested frequency onto the discrete hardware bins
module pfv_freq_bin (
    input  wire logic [11:0] freq_khz_i, // Requested frequency, kHz
    output logic      [10:0] bin_khz_o   // Effective frequency, kHz
);

    ////////////////////////////////////////////////////////////////////////////////
    // Gap values (250, 300, ...) fall into the lower bin
    always_comb begin
        if (freq_khz_i <= 12'h0fa) begin // Up to 250
            bin_khz_o = 11'h0e1; // 225
        end else if (freq_khz_i <= 12'h12c) begin // Up to 300
            bin_khz_o = 11'h113; // 275
        end else if (freq_khz_i <= 12'h15e) begin // Up to 350
            bin_khz_o = 11'h145; // 325
        end else if (freq_khz_i <= 12'h19a) begin // Up to 410
            bin_khz_o = 11'h177; // 375
        end else if (freq_khz_i <= 12'h1f4) begin // Up to 500
            bin_khz_o = 11'h1c2; // 450
        end else if (freq_khz_i <= 12'h258) begin // Up to 600
            bin_khz_o = 11'h226; // 550
        end else if (freq_khz_i <= 12'h2bc) begin // Up to 700
            bin_khz_o = 11'h28a; // 650
        end else if (freq_khz_i <= 12'h334) begin // Up to 820
            bin_khz_o = 11'h2ee; // 750
        end else if (freq_khz_i <= 12'h3e8) begin // Up to 1000
            bin_khz_o = 11'h384; // 900
        end else if (freq_khz_i <= 12'h4b0) begin // Up to 1200
            bin_khz_o = 11'h44c; // 1100
        end else if (freq_khz_i <= 12'h578) begin // Up to 1400
            bin_khz_o = 11'h514; // 1300
        end else begin // Up to 1650
            bin_khz_o = 11'h5dc; // 1500
        end
    end

endmodule // pfv_freq_bin

// File: rtl/pfv_config.sv
`timescale 1ns/1ps
`include "pfv_map.svh"
module pfv_config #(
    parameter logic [15:0] VOUT_LIM_LO = 16'h0000, // Lowest valid output voltage word
    parameter logic [15:0] VOUT_LIM_HI = 16'h5800  // Highest valid output voltage word
) (
    input  wire logic        clk_sys_i,       // System clock, 250 MHz
    input  wire logic        rstn_i,          // Power-on reset, active low
    input  wire logic        cmd_valid_i,     // Word transaction strobe
    input  wire logic        cmd_write_i,     // 1 write word, 0 read word
    input  wire logic [7:0]  cmd_code_i,      // Command code
    input  wire logic [15:0] cmd_wdata_i,     // Write data word
    output logic             rsp_valid_o,     // Answer strobe
    output logic      [15:0] rsp_rdata_o,     // Read data word
    input  wire logic        status_clear_i,  // Clears the sticky faults
    output logic             data_fault_o,    // Sticky invalid data flag
    output logic             cmd_fault_o,     // Sticky unsupported command flag
    output logic             host_notify_o,   // One-cycle host notification
    input  wire logic        conversion_en_i, // Power conversion enabled
    input  wire logic        nvm_restore_i,   // Restore-all pulse
    input  wire logic [10:0] nvm_freq_khz_i,  // Stored frequency, kHz
    input  wire logic [10:0] nvm_turn_on_mantissa_i,   // Stored turn-on mantissa
    input  wire logic [15:0] nvm_vout_min_i,  // Stored minimum output word
    input  wire logic        supply_uvlo_i,   // Analog supply below lockout
    input  wire logic [9:0]  vin_sense_i,     // Sensed input, 1/16 V units
    output logic      [10:0] freq_eff_khz_o,  // Applied frequency bin, kHz
    output logic      [5:0]  turn_on_code_o,  // Applied threshold code
    output logic      [15:0] vout_min_o,      // Minimum output word
    output logic             low_vin_mask_o   // Low-input fault masked
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    logic                  init_q;         // First cycle after reset release
    pfv_pkg::pfv_word_t    freq_reg_q;     // Frequency word as read back
    pfv_pkg::pfv_word_t    von_reg_q;      // Turn-on word as read back
    pfv_pkg::pfv_word_t    vout_min_q;     // Minimum output word
    pfv_pkg::pfv_khz_t     freq_hw_q;      // Frequency used by hardware
    pfv_pkg::pfv_von_code_t von_hw_q;      // Threshold used by hardware
    logic                  mask_q;         // Low-input fault mask
    logic                  rsp_valid_q;    // Answer strobe
    pfv_pkg::pfv_word_t    rsp_rdata_q;    // Answer data
    logic                  data_fault_q;   // Sticky invalid data
    logic                  cmd_fault_q;    // Sticky unsupported command
    logic                  notify_q;       // Notification pulse

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode

    logic wr_freq;      // Write to the frequency word
    logic wr_von;       // Write to the turn-on word
    logic wr_vmin;      // Write to the minimum output word
    logic known_cmd;    // Code is one of ours
    logic load_nvm;     // Reload from memory this cycle

    always_comb begin
        wr_freq   = cmd_valid_i && cmd_write_i && (cmd_code_i == `PFV_CMD_FREQ_SWITCH);
        wr_von    = cmd_valid_i && cmd_write_i && (cmd_code_i == `PFV_CMD_VIN_ON);
        wr_vmin   = cmd_valid_i && cmd_write_i && (cmd_code_i == `PFV_CMD_VOUT_MIN);
        known_cmd = (cmd_code_i == `PFV_CMD_FREQ_SWITCH) ||
                    (cmd_code_i == `PFV_CMD_VIN_ON) ||
                    (cmd_code_i == `PFV_CMD_VOUT_MIN);
        load_nvm  = init_q || nvm_restore_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frequency word built from the stored kHz value

    pfv_pkg::pfv_word_t nvm_freq_word; // Stored frequency as SLINEAR11

    // Above 1023 kHz the mantissa no longer fits, so step the exponent to 1
    always_comb begin
        if (nvm_freq_khz_i > `PFV_MAN_POS_MAX) begin
            nvm_freq_word = {5'h01, 1'b0, nvm_freq_khz_i[10:1]};
        end else begin
            nvm_freq_word = {5'h00, nvm_freq_khz_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decoders

    logic [11:0] wr_freq_khz;  // Decoded write frequency
    logic        wr_freq_neg;  // Write frequency negative
    logic        wr_freq_ovf;  // Write frequency too large
    logic [11:0] st_freq_khz;  // Decoded stored frequency
    logic [9:0]  von_16th;     // Decoded threshold, 1/16 V
    logic        von_neg;      // Threshold negative
    logic        von_ovf;      // Threshold too large
    pfv_pkg::pfv_word_t st_freq_word; // Stored-side frequency source
    pfv_pkg::pfv_word_t von_word;     // Turn-on decoder source

    always_comb begin
        st_freq_word = load_nvm ? nvm_freq_word : freq_reg_q;
        // Memory restore always brings back the fixed exponent
        von_word = load_nvm ? {`PFV_TURN_ON_EXPONENT_RST, nvm_turn_on_mantissa_i} : cmd_wdata_i;
    end

    // Write-side frequency, SLINEAR11 in kHz
    pfv_slinear_dec #(
        .SHIFT (`PFV_FREQ_SHIFT),
        .OUT_W (12)
    ) u_dec_wr_freq (
        .word_i     (cmd_wdata_i),
        .value_o    (wr_freq_khz),
        .negative_o (wr_freq_neg),
        .overflow_o (wr_freq_ovf)
    );

    // Stored-side frequency, for restore and lockout reapply
    pfv_slinear_dec #(
        .SHIFT (`PFV_FREQ_SHIFT),
        .OUT_W (12)
    ) u_dec_st_freq (
        .word_i     (st_freq_word),
        .value_o    (st_freq_khz),
        .negative_o (),
        .overflow_o ()
    );

    // Turn-on threshold, fine units so range checks see fractions
    pfv_slinear_dec #(
        .SHIFT (`PFV_VON_SHIFT),
        .OUT_W (10)
    ) u_dec_von (
        .word_i     (von_word),
        .value_o    (von_16th),
        .negative_o (von_neg),
        .overflow_o (von_ovf)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Validity and hardware mapping

    logic        freq_ok;      // Write frequency in range
    logic        von_ok;       // Turn-on value in range
    logic        vmin_ok;      // Minimum output in range
    logic        bad_write;    // Any rejected write
    logic [11:0] bin_src;      // Frequency fed to the bin map
    logic [10:0] bin_khz;      // Resulting bin
    logic [5:0]  von_code;     // Threshold code after round down
    logic        apply_freq;   // Load the hardware frequency
    logic        apply_wr;     // Hardware takes the written frequency

    always_comb begin
        freq_ok = !wr_freq_neg && !wr_freq_ovf &&
                  (wr_freq_khz >= `PFV_FREQ_MIN_KHZ) &&
                  (wr_freq_khz < `PFV_FREQ_MAX_KHZ);
        // Any binary value in range is kept as written
        von_ok  = !von_neg && !von_ovf &&
                  (von_16th >= `PFV_VON_MIN_16TH) && (von_16th <= `PFV_VON_MAX_16TH);
        vmin_ok = (cmd_wdata_i >= VOUT_LIM_LO) && (cmd_wdata_i <= VOUT_LIM_HI);
        bad_write = (wr_freq && !freq_ok) || (wr_von && !von_ok) || (wr_vmin && !vmin_ok);
        // Dropping the two fraction bits floors to the 0.25 V step
        von_code = 6'(von_16th[9:2] - `PFV_VON_BASE_QTR);
        // Written value reaches hardware at write time only with conversion off; lockout reapplies it later
        apply_wr   = wr_freq && freq_ok && !conversion_en_i && !load_nvm;
        apply_freq = apply_wr || load_nvm || supply_uvlo_i;
        bin_src    = apply_wr ? wr_freq_khz : st_freq_khz;
    end

    pfv_freq_bin u_freq_bin (
        .freq_khz_i (bin_src),
        .bin_khz_o  (bin_khz)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release marker, catches memory contents once after reset
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            init_q <= 1'b1;
        end else begin
            init_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Readback words; a rejected write leaves the old value
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            freq_reg_q <= 16'h0000;
            von_reg_q  <= {`PFV_TURN_ON_EXPONENT_RST, 11'h000};
            vout_min_q <= 16'h0000;
        end else if (load_nvm) begin
            freq_reg_q <= nvm_freq_word;
            von_reg_q  <= {`PFV_TURN_ON_EXPONENT_RST, nvm_turn_on_mantissa_i};
            vout_min_q <= nvm_vout_min_i;
        end else begin
            if (wr_freq && freq_ok) begin
                freq_reg_q <= cmd_wdata_i;
            end
            if (wr_von && von_ok) begin
                von_reg_q <= cmd_wdata_i;
            end
            if (wr_vmin && vmin_ok) begin
                vout_min_q <= cmd_wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Hardware frequency: blocked while converting until restore or lockout
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            freq_hw_q <= 11'h000;
        end else if (apply_freq) begin
            freq_hw_q <= bin_khz;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Hardware threshold follows every accepted write at once
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            von_hw_q <= 6'h00;
        end else if (load_nvm) begin
            // Out-of-range stored values clamp to the end steps
            if (von_neg || von_16th < `PFV_VON_MIN_16TH) begin
                von_hw_q <= 6'h00;
            end else if (von_ovf || von_16th > `PFV_VON_MAX_16TH) begin
                von_hw_q <= 6'h3f;
            end else begin
                von_hw_q <= von_code;
            end
        end else if (wr_von && von_ok) begin
            von_hw_q <= von_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Low-input fault mask; enable toggles and restores never touch it
    logic [9:0] thr_16th; // Applied threshold in 1/16 V

    always_comb begin
        thr_16th = 10'({(8'(von_hw_q) + `PFV_VON_BASE_QTR), 2'b00});
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            mask_q <= 1'b1;
        end else if (!init_q && vin_sense_i > thr_16th) begin
            mask_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Answer to each transaction, one cycle after it is taken
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= 16'h0000;
        end else begin
            rsp_valid_q <= cmd_valid_i;
            rsp_rdata_q <= 16'h0000;
            if (cmd_valid_i && !cmd_write_i) begin
                if (cmd_code_i == `PFV_CMD_FREQ_SWITCH) begin
                    rsp_rdata_q <= freq_reg_q;
                end else if (cmd_code_i == `PFV_CMD_VIN_ON) begin
                    rsp_rdata_q <= von_reg_q;
                end else if (cmd_code_i == `PFV_CMD_VOUT_MIN) begin
                    rsp_rdata_q <= vout_min_q;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky faults and notification; a new fault beats a clear
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            data_fault_q <= 1'b0;
            cmd_fault_q  <= 1'b0;
            notify_q     <= 1'b0;
        end else begin
            if (bad_write) begin
                data_fault_q <= 1'b1;
            end else if (status_clear_i) begin
                data_fault_q <= 1'b0;
            end
            if (cmd_valid_i && !known_cmd) begin
                cmd_fault_q <= 1'b1;
            end else if (status_clear_i) begin
                cmd_fault_q <= 1'b0;
            end
            notify_q <= bad_write || (cmd_valid_i && !known_cmd);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    always_comb begin
        rsp_valid_o    = rsp_valid_q;
        rsp_rdata_o    = rsp_rdata_q;
        data_fault_o   = data_fault_q;
        cmd_fault_o    = cmd_fault_q;
        host_notify_o  = notify_q;
        freq_eff_khz_o = freq_hw_q;
        turn_on_code_o = von_hw_q;
        vout_min_o     = vout_min_q;
        low_vin_mask_o = mask_q;
    end

endmodule // pfv_config

// File: test/pfv_config_assertions.sv
`timescale 1ns/1ps
// Port checks of the config block
module pfv_config_assertions #(
    parameter logic [15:0] VOUT_LIM_HI = 16'h5800 // Top valid word
) (
    input wire logic        clk_sys_i,       // Clock
    input wire logic        rstn_i,          // Reset
    input wire logic        cmd_valid_i,     // Strobe
    input wire logic        cmd_write_i,     // Write
    input wire logic [7:0]  cmd_code_i,      // Code
    input wire logic [15:0] cmd_wdata_i,     // Word
    input wire logic        status_clear_i,  // Clear
    input wire logic        conversion_en_i, // Conv on
    input wire logic        nvm_restore_i,   // Restore
    input wire logic        supply_uvlo_i,   // Lockout
    input wire logic [9:0]  vin_sense_i,     // Input
    input wire logic        rsp_valid_o,     // Answer
    input wire logic        data_fault_o,    // Fault
    input wire logic        host_notify_o,   // Notify
    input wire logic [10:0] freq_eff_khz_o,  // Bin
    input wire logic [5:0]  turn_on_code_o,  // Code
    input wire logic        low_vin_mask_o   // Mask
);
    ////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    logic       wr_s;    // Write strobe
    logic [9:0] von_lvl; // Threshold, 1/16 V
    assign wr_s = cmd_valid_i & cmd_write_i;
    assign von_lvl = {({2'h0, turn_on_code_o} + 8'h0a), 2'h0};
    property p_rsp; cmd_valid_i |=> rsp_valid_o; endproperty
    a_rsp: assert property (p_rsp) else $error("no answer");
    property p_vout; wr_s && cmd_code_i == 8'h2b && cmd_wdata_i > VOUT_LIM_HI
        |=> host_notify_o && data_fault_o; endproperty
    a_vout: assert property (p_vout) else $error("bad min kept");
    property p_von_lo; wr_s && cmd_code_i == 8'h35 && cmd_wdata_i[15:11] == 5'h1e
        && cmd_wdata_i[10:0] < 11'h00a |=> host_notify_o && data_fault_o; endproperty
    a_von_lo: assert property (p_von_lo) else $error("low on kept");
    property p_sticky; data_fault_o && !status_clear_i |=> data_fault_o; endproperty
    a_sticky: assert property (p_sticky) else $error("fault lost");
    property p_fset; $past(rstn_i) && wr_s && cmd_code_i == 8'h33 && !nvm_restore_i
        && !conversion_en_i && cmd_wdata_i == 16'h01f4 |=> freq_eff_khz_o == 11'h1c2;
    endproperty
    a_fset: assert property (p_fset) else $error("bin not applied");
    property p_fhold; $past(rstn_i) && conversion_en_i && !nvm_restore_i
        && !supply_uvlo_i |=> $stable(freq_eff_khz_o); endproperty
    a_fhold: assert property (p_fhold) else $error("freq moved");
    property p_vhold; $past(rstn_i) && !wr_s && !nvm_restore_i
        |=> $stable(turn_on_code_o); endproperty
    a_vhold: assert property (p_vhold) else $error("code moved");
    property p_mclr; $past(rstn_i) && low_vin_mask_o && vin_sense_i > von_lvl
        |=> !low_vin_mask_o; endproperty
    a_mclr: assert property (p_mclr) else $error("mask kept");
    property p_mkeep; !low_vin_mask_o |=> !low_vin_mask_o; endproperty
    a_mkeep: assert property (p_mkeep) else $error("mask re-armed");
endmodule // pfv_config_assertions

// File: test/pfv_host.sv
`timescale 1ns/1ps
// Host side: one word transaction at a time
module pfv_host (
    input  wire logic        clk_sys_i,   // Clock
    input  wire logic        rsp_valid_i, // Answer
    input  wire logic [15:0] rsp_rdata_i, // Read word
    output logic             cmd_valid_o, // Strobe
    output logic             cmd_write_o, // Write
    output logic      [7:0]  cmd_code_o,  // Code
    output logic      [15:0] cmd_wdata_o  // Word
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_code_o = 8'h00;
        cmd_wdata_o = 16'h0000;
    end
    // Strobe one cycle; the answer stands the cycle after the take
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic ok, output logic [15:0] r);
        @(posedge clk_sys_i);
        cmd_valid_o <= 1'b1;
        cmd_write_o <= w;
        cmd_code_o <= c;
        cmd_wdata_o <= d;
        @(posedge clk_sys_i);
        cmd_valid_o <= 1'b0;
        cmd_wdata_o <= ~d; // Stale word flips, never passes for data
        #1;
        ok = rsp_valid_i;
        r = rsp_rdata_i;
    endtask
endmodule // pfv_host

// File: test/tb_pfv_config.sv
`timescale 1ns/1ps
module tb_pfv_config;
    logic        clk_sys_i = 1'b0, rstn_i = 1'b0, status_clear_i = 1'b0;
    logic        conversion_en_i = 1'b0, nvm_restore_i = 1'b0, supply_uvlo_i = 1'b0;
    logic [10:0] nvm_freq_khz_i = 11'h5dc, nvm_turn_on_mantissa_i = 11'h014; // 1500 kHz, 5 V
    logic [15:0] nvm_vout_min_i = 16'h1234; // Tied minimum word
    logic [9:0]  vin_sense_i = 10'h000;
    logic        cmd_valid_i, cmd_write_i, rsp_valid_o, data_fault_o, cmd_fault_o;
    logic        host_notify_o, low_vin_mask_o;
    logic [7:0]  cmd_code_i;
    logic [15:0] cmd_wdata_i, rsp_rdata_o, vout_min_o;
    logic [10:0] freq_eff_khz_o;
    logic [5:0]  turn_on_code_o;
    int          n_fail = 0, cmp_count = 0;
    always #2 clk_sys_i = ~clk_sys_i;
    pfv_config pfv_config_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i),
        .cmd_wdata_i(cmd_wdata_i), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
        .status_clear_i(status_clear_i), .data_fault_o(data_fault_o),
        .cmd_fault_o(cmd_fault_o), .host_notify_o(host_notify_o),
        .conversion_en_i(conversion_en_i), .nvm_restore_i(nvm_restore_i),
        .nvm_freq_khz_i(nvm_freq_khz_i), .nvm_turn_on_mantissa_i(nvm_turn_on_mantissa_i),
        .nvm_vout_min_i(nvm_vout_min_i), .supply_uvlo_i(supply_uvlo_i),
        .vin_sense_i(vin_sense_i), .freq_eff_khz_o(freq_eff_khz_o),
        .turn_on_code_o(turn_on_code_o), .vout_min_o(vout_min_o),
        .low_vin_mask_o(low_vin_mask_o));
    pfv_host pfv_host_inst (.clk_sys_i(clk_sys_i), .rsp_valid_i(rsp_valid_o),
        .rsp_rdata_i(rsp_rdata_o), .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
        .cmd_code_o(cmd_code_i), .cmd_wdata_o(cmd_wdata_i));
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    // Write, then judge answer, notify and fault; a fault is cleared after
    task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic f);
        logic ok;
        logic [15:0] r;
        pfv_host_inst.xfer(1'b1, c, d, ok, r);
        chk("answer", 16'h0001, 16'(ok));
        chk("notify", 16'(f), 16'(host_notify_o));
        chk("fault", 16'(f), 16'(data_fault_o));
        @(posedge clk_sys_i);
        status_clear_i <= f;
        @(posedge clk_sys_i);
        status_clear_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        logic ok;
        logic [15:0] r;
        pfv_host_inst.xfer(1'b0, c, 16'h0000, ok, r);
        chk("answer", 16'h0001, 16'(ok));
        chk("rdata", e, r);
    endtask
    // Even values above 1023 use exponent 1
    function automatic logic [15:0] fenc(input logic [11:0] k);
        return (k < 12'h400) ? {5'h00, k[10:0]} : {5'h01, k[11:1]};
    endfunction
    task automatic t_reset();
        chk("freq", 16'h05dc, 16'(freq_eff_khz_o));
        chk("code", 16'h000a, 16'(turn_on_code_o));
        chk("mask", 16'h0001, 16'(low_vin_mask_o));
        chk("vmin", 16'h1234, vout_min_o);
        rd(8'h33, 16'h0aee);
        rd(8'h35, 16'hf014);
        $display("t_reset done");
    endtask
    task automatic t_bins();
        logic [11:0] rq [16] = '{12'h0fa, 12'h0fb, 12'h12c, 12'h12d, 12'h19a, 12'h1f4,
            12'h258, 12'h2bc, 12'h334, 12'h3e8, 12'h3ea, 12'h4b0, 12'h4b2, 12'h578,
            12'h670, 12'h3e9};
        logic [10:0] ex [16] = '{11'h0e1, 11'h113, 11'h113, 11'h145, 11'h177, 11'h1c2,
            11'h226, 11'h28a, 11'h2ee, 11'h384, 11'h44c, 11'h44c, 11'h514, 11'h514,
            11'h5dc, 11'h44c};
        // External rail assumed for the writes above 1100 kHz
        for (int i = 0; i < 16; i++) begin
            wr(8'h33, fenc(rq[i]), 1'b0);
            chk("bin", 16'(ex[i]), 16'(freq_eff_khz_o));
        end
        wr(8'h33, 16'h0b39, 1'b1);
        chk("bin", 16'h044c, 16'(freq_eff_khz_o));
        rd(8'h33, 16'h03e9);
        $display("t_bins done");
    endtask
    task automatic t_hold();
        conversion_en_i <= 1'b1;
        wr(8'h33, 16'h01c2, 1'b0);
        chk("bin", 16'h044c, 16'(freq_eff_khz_o));
        rd(8'h33, 16'h01c2);
        supply_uvlo_i <= 1'b1;
        @(posedge clk_sys_i);
        supply_uvlo_i <= 1'b0;
        #1 chk("bin", 16'h01c2, 16'(freq_eff_khz_o));
        wr(8'h33, 16'h0384, 1'b0);
        nvm_restore_i <= 1'b1;
        @(posedge clk_sys_i);
        nvm_restore_i <= 1'b0;
        #1 chk("bin", 16'h05dc, 16'(freq_eff_khz_o));
        $display("t_hold done");
    endtask
    task automatic t_von();
        logic [15:0] vw [6] = '{16'hf00d, 16'he03b, 16'hf049, 16'hf04a, 16'hf009, 16'hf00a};
        logic        vf [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        logic [5:0]  vc [6] = '{6'h03, 6'h04, 6'h3f, 6'h3f, 6'h3f, 6'h00};
        for (int i = 0; i < 6; i++) begin
            wr(8'h35, vw[i], vf[i]);
            chk("code", 16'(vc[i]), 16'(turn_on_code_o));
        end
        rd(8'h35, 16'hf00a);
        rd(8'h34, 16'h0000);
        chk("cmd", 16'h0001, 16'(cmd_fault_o));
        wr(8'h2b, 16'h5800, 1'b0);
        wr(8'h2b, 16'h5801, 1'b1);
        rd(8'h2b, 16'h5800);
        $display("t_von done");
    endtask
    task automatic t_mask();
        @(posedge clk_sys_i);
        vin_sense_i <= 10'h028;
        repeat (3) @(posedge clk_sys_i);
        #1 chk("mask", 16'h0001, 16'(low_vin_mask_o));
        vin_sense_i <= 10'h029;
        repeat (2) @(posedge clk_sys_i);
        #1 chk("mask", 16'h0000, 16'(low_vin_mask_o));
        vin_sense_i <= 10'h000;
        conversion_en_i <= 1'b0;
        nvm_restore_i <= 1'b1;
        @(posedge clk_sys_i);
        nvm_restore_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1 chk("mask", 16'h0000, 16'(low_vin_mask_o));
        $display("t_mask done");
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #100000 n_fail++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1 t_reset();
        t_bins();
        t_hold();
        t_von();
        t_mask();
        end_of_test();
    end
endmodule // tb_pfv_config
bind pfv_config pfv_config_assertions #(.VOUT_LIM_HI(VOUT_LIM_HI)) pfv_config_assertions_inst (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i),
    .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i),
    .status_clear_i(status_clear_i), .conversion_en_i(conversion_en_i),
    .nvm_restore_i(nvm_restore_i), .supply_uvlo_i(supply_uvlo_i),
    .vin_sense_i(vin_sense_i), .rsp_valid_o(rsp_valid_o), .data_fault_o(data_fault_o),
    .host_notify_o(host_notify_o), .freq_eff_khz_o(freq_eff_khz_o),
    .turn_on_code_o(turn_on_code_o), .low_vin_mask_o(low_vin_mask_o));
